// *** hdl/ser_if_pkg.sv ***
// ser_if_pkg: shared constants, types and bit helpers of the serial interface
package ser_if_pkg;

  // ----------------------------------------------------------------
  // operating mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_MST_D4 = 3'h0;
  localparam logic [2:0] MODE_MST_D16 = 3'h1;
  localparam logic [2:0] MODE_MST_D64 = 3'h2;
  localparam logic [2:0] MODE_MST_SUB = 3'h3;
  localparam logic [2:0] MODE_MST_TMR = 3'h4;
  localparam logic [2:0] MODE_SPI_SLV = 3'h5;
  localparam logic [2:0] MODE_I2C_SLV = 3'h6;

  // ----------------------------------------------------------------
  // timing and framing counts
  // ----------------------------------------------------------------
  localparam logic [5:0] HALF_D4 = 6'h02;
  localparam logic [5:0] HALF_D16 = 6'h08;
  localparam logic [5:0] HALF_D64 = 6'h20;
  localparam logic [5:0] HALF_ONE = 6'h01;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam logic [4:0] EDGES_PER_XFER = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int SY_SDI = 0;
  localparam int SY_SCL = 1;
  localparam int SY_SDA = 2;
  localparam int SY_DONE = 3;
  localparam int SY_ACT = 4;

  // ----------------------------------------------------------------
  // state types, one bit changes per step from idle up to the last state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_RUN = 2'b01, M_END = 2'b11} mst_state_e;
  typedef enum logic [1:0] {I_IDLE = 2'b00, I_DATA = 2'b01, I_ACK = 2'b11} i2c_state_e;

  // bit of a byte at transfer position idx, in the chosen shift order
  function automatic logic bit_at(input logic [7:0] b, input logic [2:0] idx, input logic msb);
    bit_at = msb ? b[LAST_BIT - idx] : b[idx];
  endfunction : bit_at

  // shift one received bit into a byte, in the chosen shift order
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic msb);
    shift_in = msb ? {b[6:0], d} : {d, b[7:1]};
  endfunction : shift_in

endpackage : ser_if_pkg

// *** hdl/bit_sync.sv ***
// bit_sync: two flip-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule : bit_sync

// *** hdl/ser_if_core.sv ***
// ser_if_core: spi master/slave and i2c slave engine around one shared data byte
// Function
// - nothing is transferred until interface_enable is high
// - master mode: data write starts a full duplex transfer at once
// - transfer_done_flag sets at each transfer end, stays until software clears it
// - slave mode: external clock edges shift data out and serial_data_in in
// - slave output data timed against select by clock polarity and edge selects
// - edge select 0: serial_data_out holds its level until the first clock edge
// - edge select 1: serial_data_out shows the first bit right after the write
// - slave mode with select_pin_enable high: serial_data_out floats while slave_select_pin is high
// - slave with select_pin_enable low is always active, ignoring the select pin
// - each transfer moves eight bits, msb-first or lsb-first order
// - spi keeps running in the processor idle low-power mode
// - i2c mode drives sda and scl only open-drain, pull-ups give high
// - i2c has no select line; devices are chosen by address on the bus
// - i2c mode is slave only: slave transmit and slave receive
// - pin pull-ups stay under their pull-up control during i2c mode
// - spi shift order high sends msb first, low sends lsb first; i2c always sends msb first
// - data write during a master or spi slave transfer is ignored and sets write_collision_flag
// - select_pin_enable low floats slave_select_pin, high makes it the select
`timescale 1ns/10ps
module ser_if_core
  import ser_if_pkg::*;
(
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // configuration
  input wire logic i_enable,
  input wire logic [2:0] i_mode,
  input wire logic i_clk_pol,
  input wire logic i_clk_edge,
  input wire logic i_msb_first,
  input wire logic i_sel_en,
  input wire logic i_sub_tick,
  input wire logic i_tmr_tick,
  input wire logic i_i2c_tx,
  input wire logic i_i2c_ack,
  input wire logic [1:0] i_pullup_ctl,
  // software data and flags
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_data,
  input wire logic i_done_clr,
  input wire logic i_coll_clr,
  output logic [7:0] o_data,
  output logic o_transfer_done,
  output logic o_write_collision,
  output logic o_busy,
  output logic o_irq,
  // spi pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_ss_n,
  output logic o_ss_n,
  output logic o_ss_oe,
  // i2c pins
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output logic [1:0] o_pullup_en
);

  // ----------------------------------------------------------------
  // mode decode and shared state
  // ----------------------------------------------------------------
  logic is_master;
  logic is_slave;
  logic is_i2c;
  logic slave_sel;
  logic busy;
  logic wr_ok;
  logic coll_evt;
  logic xfer_evt;
  logic m_done;
  logic s_done;
  logic i2c_done;
  logic [7:0] data_reg;
  logic done_reg;
  logic coll_reg;
  logic [SYNC_W-1:0] sy;

  // a disabled interface decodes no mode, so every engine stays idle
  assign is_master = i_enable && (i_mode <= MODE_MST_TMR);
  assign is_slave = i_enable && (i_mode == MODE_SPI_SLV);
  assign is_i2c = i_enable && (i_mode == MODE_I2C_SLV);
  // select ignored when the pin is disabled
  assign slave_sel = is_slave && (!i_sel_en || !i_ss_n);

  // ----------------------------------------------------------------
  // synchronisers for pins and link-domain events
  // ----------------------------------------------------------------
  logic s_act_reg;
  logic s_done_tgl_reg;
  logic done_seen_reg;

  bit_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({s_act_reg, s_done_tgl_reg, i_sda, i_scl, i_sdi}),
    .o_sync(sy)
  );

  // ----------------------------------------------------------------
  // software data register and sticky flags
  // ----------------------------------------------------------------
  logic [7:0] m_rx_reg;
  logic [7:0] s_rx_hold_reg;
  logic [7:0] i_rx_reg;
  mst_state_e m_state;

  assign busy = (m_state != M_IDLE) || sy[SY_ACT];
  assign wr_ok = i_wr_stb && !busy;
  assign coll_evt = i_wr_stb && busy;
  assign xfer_evt = m_done || s_done || i2c_done;

  // writes during a master or spi slave transfer never reach the data byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_reg <= 8'h00;
    end else if (wr_ok) begin
      data_reg <= i_wr_data;
    end else if (m_done) begin
      data_reg <= m_rx_reg;
    end else if (s_done) begin
      data_reg <= s_rx_hold_reg;
    end else if (i2c_done) begin
      data_reg <= i_rx_reg;
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else begin
      done_reg <= xfer_evt || (done_reg && !i_done_clr);
      coll_reg <= coll_evt || (coll_reg && !i_coll_clr);
    end
  end

  // pull-up control passes on in every mode, i2c included
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pullup_en <= 2'h0;
    end else begin
      o_pullup_en <= i_pullup_ctl;
    end
  end

  assign o_data = data_reg;
  assign o_transfer_done = done_reg;
  assign o_write_collision = coll_reg;
  assign o_busy = busy;
  assign o_irq = done_reg;

  // ----------------------------------------------------------------
  // spi master: clock divider and shifter
  // ----------------------------------------------------------------
  logic [5:0] half_lim;
  logic [5:0] m_half_cnt;
  logic [4:0] m_edge_cnt;
  logic [3:0] m_smp_cnt;
  logic m_tick;
  logic m_sample;
  logic m_sck_reg;
  logic m_sdo_reg;

  // half period of the generated clock per divider mode
  always_comb begin
    case (i_mode)
      MODE_MST_D16: half_lim = HALF_D16;
      MODE_MST_D64: half_lim = HALF_D64;
      default: half_lim = HALF_D4;
    endcase
  end

  // external ticks toggle the clock directly, giving their rate over two
  assign m_tick = (i_mode == MODE_MST_SUB) ? i_sub_tick :
                  (i_mode == MODE_MST_TMR) ? i_tmr_tick : (m_half_cnt == (half_lim - HALF_ONE));
  // even edge index is a leading edge
  assign m_sample = i_clk_edge ? !m_edge_cnt[0] : m_edge_cnt[0];
  assign m_done = (m_state == M_END);

  // master sequencing: a write starts the transfer at once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_state <= M_IDLE;
    end else begin
      case (m_state)
        M_IDLE: if (wr_ok && is_master) m_state <= M_RUN;
        M_RUN: if (!is_master) m_state <= M_IDLE;
               else if (m_tick && (m_edge_cnt == (EDGES_PER_XFER - 5'h01))) m_state <= M_END;
        M_END: m_state <= M_IDLE;
        default: m_state <= M_IDLE;
      endcase
    end
  end

  // divider and edge counters
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_half_cnt <= 6'h00;
      m_edge_cnt <= 5'h00;
      m_sck_reg <= 1'b0;
    end else if (m_state != M_RUN) begin
      m_half_cnt <= 6'h00;
      m_edge_cnt <= (m_state == M_END) ? m_edge_cnt : 5'h00;
      m_sck_reg <= !i_clk_pol;
    end else begin
      m_half_cnt <= m_tick ? 6'h00 : (m_half_cnt + 6'h01);
      m_edge_cnt <= m_tick ? (m_edge_cnt + 5'h01) : m_edge_cnt;
      m_sck_reg <= m_tick ? !m_sck_reg : m_sck_reg;
    end
  end

  // shifting: receive on sample edges, drive the next bit on the others
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_smp_cnt <= 4'h0;
      m_rx_reg <= 8'h00;
      m_sdo_reg <= 1'b0;
    end else if (wr_ok && is_master) begin
      m_smp_cnt <= 4'h0;
      if (i_clk_edge) m_sdo_reg <= bit_at(i_wr_data, 3'h0, i_msb_first);
    end else if ((m_state == M_RUN) && m_tick) begin
      if (m_sample) begin
        m_rx_reg <= shift_in(m_rx_reg, sy[SY_SDI], i_msb_first);
        m_smp_cnt <= m_smp_cnt + 4'h1;
      end else if (m_smp_cnt < BITS_PER_XFER) begin
        m_sdo_reg <= bit_at(data_reg, m_smp_cnt[2:0], i_msb_first);
      end
    end
  end

  assign o_sck = m_sck_reg;
  assign o_sck_oe = is_master;
  assign o_ss_n = !(m_state != M_IDLE);
  assign o_ss_oe = is_master && i_sel_en;

  // ----------------------------------------------------------------
  // spi slave: logic on the external master's clock
  // ----------------------------------------------------------------
  // the link clock is folded so that its rising edge is always the sample edge;
  // it runs whenever the master clocks, idle mode included
  logic lnk_clk;
  logic lnk_rst_n;
  logic [2:0] s_cnt_reg;
  logic [7:0] s_rx_reg;
  logic s_sdo_reg;
  logic s_sdo;

  assign lnk_clk = i_sck ^ i_clk_pol ^ i_clk_edge;
  assign lnk_rst_n = i_rst_n && slave_sel;

  // frame counter and receive shifter; deselect restarts the frame
  always_ff @(posedge lnk_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      s_cnt_reg <= 3'h0;
      s_rx_reg <= 8'h00;
      s_act_reg <= 1'b0;
    end else begin
      s_cnt_reg <= s_cnt_reg + 3'h1;
      s_rx_reg <= shift_in(s_rx_reg, i_sdi, i_msb_first);
      s_act_reg <= (s_cnt_reg != LAST_BIT);
    end
  end

  // completed byte and its event toggle survive the deselect
  always_ff @(posedge lnk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_rx_hold_reg <= 8'h00;
      s_done_tgl_reg <= 1'b0;
    end else if (slave_sel && (s_cnt_reg == LAST_BIT)) begin
      s_rx_hold_reg <= shift_in(s_rx_reg, i_sdi, i_msb_first);
      s_done_tgl_reg <= !s_done_tgl_reg;
    end
  end

  // outgoing bit changes only on a shift edge, so with edge select 0 a write leaves the line alone
  always_ff @(negedge lnk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_sdo_reg <= 1'b0;
    end else if (slave_sel) begin
      s_sdo_reg <= bit_at(data_reg, s_cnt_reg, i_msb_first);
    end
  end

  // edge select 1 shows the first bit before any clock edge
  assign s_sdo = (i_clk_edge && (s_cnt_reg == 3'h0)) ? bit_at(data_reg, 3'h0, i_msb_first) : s_sdo_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_seen_reg <= 1'b0;
    end else begin
      done_seen_reg <= sy[SY_DONE];
    end
  end
  assign s_done = sy[SY_DONE] ^ done_seen_reg;

  assign o_sdo = is_master ? m_sdo_reg : s_sdo;
  assign o_sdo_oe = is_master || slave_sel;

  // ----------------------------------------------------------------
  // i2c slave: byte engine on sampled bus lines
  // ----------------------------------------------------------------
  i2c_state_e i_state;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [3:0] i_bitc_reg;
  logic sda_lo_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // the master owns the clock; its edges and the start and stop conditions move this engine
  assign scl_rise = sy[SY_SCL] && !scl_d_reg;
  assign scl_fall = !sy[SY_SCL] && scl_d_reg;
  assign bus_start = sy[SY_SCL] && scl_d_reg && sda_d_reg && !sy[SY_SDA];
  assign bus_stop = sy[SY_SCL] && scl_d_reg && !sda_d_reg && sy[SY_SDA];
  assign i2c_done = (i_state == I_DATA) && scl_fall && (i_bitc_reg == BITS_PER_XFER);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= sy[SY_SCL];
      sda_d_reg <= sy[SY_SDA];
    end
  end

  // byte framing: eight bits then an acknowledge slot, until a stop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      i_state <= I_IDLE;
      i_bitc_reg <= 4'h0;
      i_rx_reg <= 8'h00;
    end else if (!is_i2c || bus_stop) begin
      i_state <= I_IDLE;
      i_bitc_reg <= 4'h0;
    end else if (bus_start) begin
      i_state <= I_DATA;
      i_bitc_reg <= 4'h0;
    end else begin
      case (i_state)
        I_DATA: begin
          if (scl_rise && (i_bitc_reg < BITS_PER_XFER)) begin
            i_rx_reg <= shift_in(i_rx_reg, sy[SY_SDA], 1'b1);
            i_bitc_reg <= i_bitc_reg + 4'h1;
          end
          if (i2c_done) i_state <= I_ACK;
        end
        I_ACK: begin
          if (scl_fall) begin
            i_state <= I_DATA;
            i_bitc_reg <= 4'h0;
          end
        end
        default: i_state <= I_IDLE;
      endcase
    end
  end

  // line drive changes on falling clock: transmit bits or the receive acknowledge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_lo_reg <= 1'b0;
    end else if (!is_i2c || bus_stop || bus_start) begin
      sda_lo_reg <= 1'b0;
    end else if (scl_fall) begin
      if (i_state == I_ACK) begin
        sda_lo_reg <= i_i2c_tx && !bit_at(data_reg, 3'h0, 1'b1);
      end else if (i_state == I_DATA && i_bitc_reg == BITS_PER_XFER) begin
        sda_lo_reg <= !i_i2c_tx && i_i2c_ack;
      end else if (i_state == I_DATA) begin
        sda_lo_reg <= i_i2c_tx && !bit_at(data_reg, i_bitc_reg[2:0], 1'b1);
      end
    end
  end

  // open drain: only ever pull low, never drive high
  assign o_sda = 1'b0;
  assign o_sda_oe = is_i2c && sda_lo_reg;
  assign o_scl = 1'b0;
  assign o_scl_oe = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_IDLE_WHEN_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_enable && m_state == M_IDLE) |-> !o_sdo_oe && !o_sda_oe && !o_sck_oe ##1 (m_state == M_IDLE))
    else $error("transfer activity while interface disabled");

  AST_WRITE_STARTS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_ok && is_master) |=> (m_state == M_RUN) && (data_reg == $past(i_wr_data)))
    else $error("master write did not start a transfer");

  AST_DONE_SETS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    xfer_evt |=> done_reg)
    else $error("done flag not set at transfer end");

  AST_DONE_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (done_reg && !i_done_clr) |=> done_reg)
    else $error("done flag dropped without a clear");

  AST_COLLISION: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (coll_evt && !xfer_evt) |=> coll_reg && (data_reg == $past(data_reg)))
    else $error("write during transfer not ignored or not flagged");

  AST_SDO_FLOATS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (is_slave && i_sel_en && i_ss_n) |-> !o_sdo_oe)
    else $error("slave output driven while deselected");

  AST_EIGHT_BITS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (m_state == M_END) |-> (m_edge_cnt == EDGES_PER_XFER) && (m_smp_cnt == BITS_PER_XFER))
    else $error("master transfer not eight bits long");

  AST_FIRST_BIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_ok && is_master && i_clk_edge) |=> (o_sdo == bit_at($past(i_wr_data), 3'h0, i_msb_first)))
    else $error("first bit not presented on write");

  AST_OPEN_DRAIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    is_i2c |-> !o_sda && !o_scl_oe && !o_sck_oe)
    else $error("i2c line driven high or clock driven");

  AST_IRQ_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (xfer_evt && !done_reg) |=> $rose(o_irq))
    else $error("interrupt request missing when done flag set");

endmodule : ser_if_core

// *** tb/spi_far_master.sv ***
// spi_far_master: behavioural external spi master that faces the slave link
`timescale 1ns/10ps
module spi_far_master (
  // link clock
  input wire logic i_lclk,
  // data back from the slave
  input wire logic i_miso,
  // master pins
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi
);
  // ----------------------------------------
  // pins idle, clock stands still outside frames
  // ----------------------------------------
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end

  // idle level is set with select so no stray edge reaches a selected slave
  task automatic sel(input logic lvl, input logic pol);
    @(posedge i_lclk);
    #1;
    o_sck = ~pol;
    o_ss_n = lvl;
  endtask : sel

  // eight bits; samples on the leading edge when edg is set, else on the trailing one
  task automatic frame(input logic pol, input logic edg, input logic msb, input logic [7:0] tx,
                       output logic [7:0] rx);
    int i;
    o_mosi = tx[msb ? 7 : 0];
    rx = 8'h00;
    for (i = 0; i < 8; i++) begin
      @(posedge i_lclk);
      #1;
      if (edg) rx[msb ? 7 - i : i] = i_miso;
      else o_mosi = tx[msb ? 7 - i : i];
      o_sck = ~o_sck;
      @(posedge i_lclk);
      #1;
      if (!edg) rx[msb ? 7 - i : i] = i_miso;
      else if (i < 7) o_mosi = tx[msb ? 6 - i : i + 1];
      o_sck = ~o_sck;
    end
    @(posedge i_lclk);
    #1 o_mosi = ~o_mosi; // released line must not look like a held bit
  endtask : frame
endmodule : spi_far_master

// *** tb/serial_interface_spi_i2c_slave_tb_top.sv ***
// serial_interface_spi_i2c_slave_tb_top: self-checking bench of the serial interface core
`timescale 1ns/10ps
module serial_interface_spi_i2c_slave_tb_top
  import ser_if_pkg::*;
;
  logic i_clk, i_rst_n, i_enable, i_clk_pol, i_clk_edge, i_msb_first, i_sel_en, i_sub_tick, i_tmr_tick;
  logic i_i2c_tx, i_i2c_ack, i_wr_stb, i_done_clr, i_coll_clr, i_sck, i_sdi, i_ss_n, i_scl, i_sda, lclk, mosi, v;
  logic o_transfer_done, o_write_collision, o_busy, o_irq, o_sck, o_sck_oe, o_sdo, o_sdo_oe, o_ss_n, o_ss_oe;
  logic o_scl, o_scl_oe, o_sda, o_sda_oe;
  logic [2:0] i_mode;
  logic [1:0] i_pullup_ctl, o_pullup_en;
  logic [7:0] i_wr_data, o_data, b, s, rx;
  int errors, check_count, tgl, cyc, n, k;
  integer seed = 32'h6c05;

  ser_if_core dut (.i_clk, .i_rst_n, .i_enable, .i_mode, .i_clk_pol, .i_clk_edge, .i_msb_first, .i_sel_en,
    .i_sub_tick, .i_tmr_tick, .i_i2c_tx, .i_i2c_ack, .i_pullup_ctl, .i_wr_stb, .i_wr_data, .i_done_clr,
    .i_coll_clr, .o_data, .o_transfer_done, .o_write_collision, .o_busy, .o_irq, .i_sck, .o_sck, .o_sck_oe,
    .i_sdi, .o_sdo, .o_sdo_oe, .i_ss_n, .o_ss_n, .o_ss_oe, .i_scl, .o_scl, .o_scl_oe, .i_sda, .o_sda,
    .o_sda_oe, .o_pullup_en);
  spi_far_master m (.i_lclk(lclk), .i_miso(o_sdo), .o_sck(i_sck), .o_ss_n(i_ss_n), .o_mosi(mosi));
  // master tests loop the data line back so the received byte is known
  assign i_sdi = (i_mode == MODE_SPI_SLV) ? mosi : o_sdo;

  // ----------------------------------------
  // clocks, toggle count and hang guard
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #6 lclk = ~lclk;
  end
  always @(o_sck) tgl++;
  // external master clock sources: a one-cycle strobe every fifth system clock
  always @(posedge i_clk) #5 {i_sub_tick, i_tmr_tick} = {2{cyc % 5 == 0}};
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task tick;
    @(posedge i_clk);
    #5;
  endtask : tick
  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task cfg(input logic [2:0] md, input logic en, input logic se, input logic [2:0] pem);
    tick();
    i_mode = md;
    i_enable = en;
    i_sel_en = se;
    {i_msb_first, i_clk_edge, i_clk_pol} = pem;
  endtask : cfg
  task wr(input logic [7:0] d);
    tick();
    i_wr_stb = 1'b1;
    i_wr_data = d;
    tick();
    i_wr_stb = 1'b0;
  endtask : wr
  task clr;
    tick();
    {i_done_clr, i_coll_clr} = 2'h3;
    tick();
    {i_done_clr, i_coll_clr} = 2'h0;
  endtask : clr
  // bounded wait; done lags the last edge by a few system clocks
  task wdone;
    for (n = 0; n < 400 && o_transfer_done !== 1'b1; n++) tick();
    chk(o_transfer_done === 1'b1, "done flag not set");
  endtask : wdone
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_enable, i_clk_pol, i_clk_edge, i_msb_first, i_sel_en} = 5'h00;
    {i_i2c_tx, i_i2c_ack, i_wr_stb, i_done_clr, i_coll_clr, i_rst_n} = 6'h00;
    {i_scl, i_sda, i_mode, i_pullup_ctl, i_wr_data} = {2'h3, 3'h7, 2'h0, 8'h00};
    repeat (5) @(posedge i_clk);
    chk(o_data === 8'h00 && o_transfer_done === 1'b0 && o_write_collision === 1'b0, "reset values");
    #5 i_rst_n = 1'b1;
    cfg(MODE_MST_D4, 1'b0, 1'b1, 3'h4);
    wr(8'hA5);
    repeat (50) tick();
    chk(o_transfer_done === 1'b0 && o_busy === 1'b0, "transfer while disabled");
    $display("test disabled done");
    // divider, sub clock and timer sources, both edge selects, select pin on and off
    for (k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      cfg((k == 0) ? MODE_MST_D16 : (k == 1) ? MODE_MST_SUB : MODE_MST_TMR, 1'b1, k[0], {k[0], !k[0], b[0]});
      repeat (3) tick();
      tgl = 0;
      wr(b);
      tick();
      chk(o_busy === 1'b1 && o_ss_n === 1'b0 && o_ss_oe === k[0], "master did not start");
      wr(~b);
      tick();
      chk(o_write_collision === 1'b1, "collision flag");
      wdone();
      chk(o_data === b && tgl == 16 && o_sck === !b[0], "master byte or edge count");
      repeat (5) tick();
      chk(o_transfer_done === 1'b1 && o_irq === 1'b1, "flag not sticky or no irq");
      clr();
      tick();
      chk(o_transfer_done === 1'b0 && o_write_collision === 1'b0, "flags not cleared");
    end
    $display("test master done");
    for (k = 0; k < 8; k++) begin
      b = 8'($random(seed));
      s = 8'($random(seed));
      m.sel(1'b1, k[0]);
      cfg(MODE_SPI_SLV, 1'b1, 1'b1, k[2:0]);
      wr(b);
      tick();
      chk(o_sdo_oe === 1'b0, "sdo driven while deselected");
      m.sel(1'b0, k[0]);
      m.frame(k[0], k[1], k[2], s, rx);
      wdone();
      chk(o_data === s && rx === b, "slave byte");
      m.sel(1'b1, k[0]);
      clr();
    end
    $display("test slave done");
    cfg(MODE_SPI_SLV, 1'b1, 1'b1, 3'h5);
    m.sel(1'b0, 1'b1);
    repeat (2) tick();
    v = o_sdo;
    wr({~v, 7'h35});
    repeat (2) tick();
    chk(o_sdo === v, "sdo moved before first edge");
    m.sel(1'b1, 1'b0);
    cfg(MODE_SPI_SLV, 1'b1, 1'b0, 3'h6);
    b = 8'($random(seed));
    wr(b);
    tick();
    chk(o_sdo === b[7] && o_sdo_oe === 1'b1 && o_ss_oe === 1'b0, "first bit at write");
    m.frame(1'b0, 1'b1, 1'b1, s, rx);
    wdone();
    chk(o_data === s && rx === b, "always-on slave byte");
    clr();
    $display("test slave edge cases done");
    b = 8'($random(seed));
    s = 8'($random(seed));
    cfg(MODE_I2C_SLV, 1'b1, 1'b0, 3'h4);
    {i_i2c_ack, i_i2c_tx, i_pullup_ctl} = {2'h2, b[1:0]};
    repeat (3) tick();
    chk(o_pullup_en === b[1:0] && o_scl_oe === 1'b0 && o_sck_oe === 1'b0 && o_ss_oe === 1'b0 && o_scl === 1'b0,
        "i2c pins");
    // start, one received byte with acknowledge, then the same byte sent back
    i_sda = 1'b0;
    for (k = 0; k < 18; k++) begin
      repeat (4) tick();
      i_scl = 1'b0;
      repeat (4) tick();
      chk(o_sda_oe === ((k == 8) || (k > 8 && k < 17 && !s[16 - k])) && o_sda === 1'b0,
          "i2c data line");
      // wired-and bus: a slave pulling low wins over the released line
      i_sda = (k < 8) ? s[7 - k] : !o_sda_oe;
      i_i2c_tx = (k >= 8);
      repeat (4) tick();
      i_scl = 1'b1;
    end
    repeat (4) tick();
    chk(o_data === s && o_transfer_done === 1'b1 && o_sda_oe === 1'b0, "i2c byte");
    $display("test i2c done");
    stop_test();
  end
endmodule : serial_interface_spi_i2c_slave_tb_top
